// *** rtl/aows_pkg.sv ***
// package: constants and carrier types of the analog output word scaler
package aows_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int WORD_W = 16;
    localparam int CODE_W = 12;
    localparam logic [11:0] CODE_MAX = 12'h0fff;
    localparam logic [11:0] CODE_MID = 12'h07ff;
    localparam logic [11:0] CODE_ZERO = 12'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_HALF = 16'h3fff;
    localparam logic [15:0] WORD_FULL = 16'h7fff;
    localparam logic [15:0] WORD_MINUS_ONE = 16'hffff;
    localparam logic [15:0] WORD_SM_NEG = 16'h8001;
    localparam int CODE_LSB = 3;
    // gain is unsigned 8.8 fixed point
    localparam int GAIN_FRAC = 8;
    localparam logic [15:0] GAIN_UNITY = 16'h0100;
    localparam logic signed [16:0] VAL_MAX = 17'sh0_ffff;
    localparam logic signed [16:0] VAL_MIN = 17'sh1_0000;
    localparam logic signed [16:0] VAL_FULL = 17'sh0_7fff;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_FACT_OFS = 8'h13;
    localparam logic [7:0] IDX_FACT_GAIN = 8'h14;
    localparam logic [7:0] IDX_FEATURE = 8'h20;
    localparam logic [7:0] IDX_USER_OFS = 8'h21;
    localparam logic [7:0] IDX_USER_GAIN = 8'h22;
    localparam logic [7:0] IDX_SUBST = 8'h23;
    localparam logic [7:0] IDX_STATUS = 8'h24;
    localparam logic [15:0] RST_OFS = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'h0100;
    localparam logic [15:0] RST_FEATURE = 16'h0000;
    localparam logic [15:0] RST_SUBST = 16'h0000;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    // feature_configuration bit positions
    localparam int FEAT_USER_EN = 0;
    localparam int FEAT_FACT_EN = 1;
    localparam int FEAT_SIGN_MAG = 2;
    localparam int STAT_EXPIRED = 0;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    localparam logic [1:0] HRESP_OKAY = 2'b00;
    localparam int WDOG_TIME_MS = 100;
    localparam int CLK_MHZ = 100;
    localparam int WDOG_CYCLES_DEF = WDOG_TIME_MS * 1000 * CLK_MHZ;

    typedef struct packed {
        logic valid;
        logic [CH_W-1:0] ch;
        logic [WORD_W-1:0] word;
    } aows_pd_t;

    typedef struct packed {
        logic [15:0] ofs;
        logic [15:0] gain;
    } aows_coef_t;
endpackage : aows_pkg

// *** rtl/aows_scaler.sv ***
// combinational word decode, two-stage linear scaling and clamp to dac code
`timescale 1ns/100ps
`default_nettype none
module aows_scaler import aows_pkg::*; (
    input wire logic [15:0] word,
    input wire logic sign_mag,
    input wire logic fact_en,
    input wire logic user_en,
    input wire aows_coef_t fact,
    input wire aows_coef_t user,
    output logic [11:0] code
);
    // offset plus gain times x; saturated to 17 bits so a second stage
    // never sees a wrapped intermediate
    function automatic logic signed [16:0] lin(
        input logic signed [16:0] x,
        input aows_coef_t c
    );
        logic signed [33:0] prod;
        logic signed [33:0] sum;
        prod = 34'(x) * 34'($signed({1'b0, c.gain}));
        sum = (prod >>> GAIN_FRAC) + 34'($signed(c.ofs));
        if (sum > 34'(VAL_MAX)) begin
            lin = VAL_MAX;
        end else if (sum < 34'(VAL_MIN)) begin
            lin = VAL_MIN;
        end else begin
            lin = sum[16:0];
        end
    endfunction : lin

    logic signed [16:0] mag;
    logic signed [16:0] x_in;
    logic signed [16:0] y_fact;
    logic signed [16:0] y_out;

    assign mag = $signed({2'b00, word[14:0]});
    assign x_in = sign_mag ? (word[15] ? -mag : mag)
                           : $signed({word[15], word});
    assign y_fact = fact_en ? lin(x_in, fact) : x_in;
    assign y_out = user_en ? lin(y_fact, user) : y_fact;
    // clamp instead of wrapping at both ends of the code range
    assign code = (y_out < 17'sh0_0000) ? CODE_ZERO
                : (y_out > VAL_FULL) ? CODE_MAX
                : y_out[CODE_LSB+11:CODE_LSB];
endmodule : aows_scaler
`default_nettype wire

// *** rtl/aows_top.sv ***
// analog output word scaler: ahb-lite registers, watchdog, per-channel scaling
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module aows_top import aows_pkg::*; #(
    parameter int WDOG_CYCLES = WDOG_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic [1:0] hresp,
    input wire aows_pd_t pd,
    output logic [NUM_CH-1:0][CODE_W-1:0] dac_code,
    output logic run_led
);
    localparam int WCNT_W = $clog2(WDOG_CYCLES + 1);
    localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WDOG_CYCLES - 1);
    localparam logic [WCNT_W-1:0] WCNT_ZERO = '0;

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == IDX_FACT_OFS) || (idx == IDX_FACT_GAIN)
                 || (idx == IDX_FEATURE) || (idx == IDX_USER_OFS)
                 || (idx == IDX_USER_GAIN) || (idx == IDX_SUBST)
                 || (idx == IDX_STATUS);
    endfunction : is_mapped

    // ---------------- register state ----------------
    logic [15:0] fact_ofs_ff;
    logic [15:0] fact_gain_ff;
    logic [15:0] feature_ff;
    logic [15:0] user_ofs_ff;
    logic [15:0] user_gain_ff;
    logic [15:0] subst_ff;
    logic expired_ff;
    logic [WCNT_W-1:0] wcnt_ff;
    logic dp_wr_ff;
    logic [7:0] dp_idx_ff;
    logic [31:0] hrdata_ff;

    // ---------------- ahb-lite address phase ----------------
    logic ap_valid;
    logic ap_inrange;
    logic [7:0] ap_idx;
    logic ap_ok;
    logic ap_read;
    logic ap_write;
    logic [15:0] rd_word;

    assign ap_valid = hsel & htrans[1] & hready;
    assign ap_inrange = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
    assign ap_idx = haddr[9:2];
    assign ap_ok = ap_inrange && (hsize == HSIZE_WORD) && is_mapped(ap_idx);
    assign ap_read = ap_valid && !hwrite;
    assign ap_write = ap_valid && hwrite && ap_ok;

    // zero wait states; only OKAY is ever answered
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_ff;

    function automatic logic [15:0] rd_mux(input logic [7:0] idx, input logic ok);
        if (!ok) begin
            rd_mux = 16'h0000;
        end else if (idx == IDX_FACT_OFS) begin
            rd_mux = fact_ofs_ff;
        end else if (idx == IDX_FACT_GAIN) begin
            rd_mux = fact_gain_ff;
        end else if (idx == IDX_FEATURE) begin
            rd_mux = feature_ff;
        end else if (idx == IDX_USER_OFS) begin
            rd_mux = user_ofs_ff;
        end else if (idx == IDX_USER_GAIN) begin
            rd_mux = user_gain_ff;
        end else if (idx == IDX_SUBST) begin
            rd_mux = subst_ff;
        end else if (idx == IDX_STATUS) begin
            rd_mux = 16'(expired_ff) << STAT_EXPIRED;
        end else begin
            rd_mux = 16'h0000;
        end
    endfunction : rd_mux

    // always_comb also wakes on the registers read inside the function; a
    // continuous assignment would only follow the index and ok arguments and could go stale
    always_comb rd_word = rd_mux(ap_idx, ap_ok);

    // read data is latched during the address phase, so it already stands
    // in the data phase; a write lands at the end of its data phase, so a read right behind it returns the old value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dp_wr_ff <= 1'b0;
            dp_idx_ff <= 8'h00;
            hrdata_ff <= RST_RDATA;
        end else if (ce) begin
            dp_wr_ff <= ap_write;
            dp_idx_ff <= ap_idx;
            if (ap_read) begin
                hrdata_ff <= {16'h0000, rd_word};
            end
        end
    end

    // ---------------- data phase writes ----------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fact_ofs_ff <= RST_OFS;
            fact_gain_ff <= RST_GAIN;
            feature_ff <= RST_FEATURE;
            user_ofs_ff <= RST_OFS;
            user_gain_ff <= RST_GAIN;
            subst_ff <= RST_SUBST;
        end else if (ce && dp_wr_ff) begin
            if (dp_idx_ff == IDX_FACT_OFS) begin
                fact_ofs_ff <= hwdata[15:0];
            end else if (dp_idx_ff == IDX_FACT_GAIN) begin
                fact_gain_ff <= hwdata[15:0];
            end else if (dp_idx_ff == IDX_FEATURE) begin
                feature_ff <= hwdata[15:0];
            end else if (dp_idx_ff == IDX_USER_OFS) begin
                user_ofs_ff <= hwdata[15:0];
            end else if (dp_idx_ff == IDX_USER_GAIN) begin
                user_gain_ff <= hwdata[15:0];
            end else if (dp_idx_ff == IDX_SUBST) begin
                subst_ff <= hwdata[15:0];
            end
        end
    end

    // ---------------- feature decode ----------------
    logic fact_en;
    logic user_en;
    logic sign_mag;
    aows_coef_t fact_coef;
    aows_coef_t user_coef;

    assign fact_en = feature_ff[FEAT_FACT_EN];
    assign user_en = feature_ff[FEAT_USER_EN];
    assign sign_mag = feature_ff[FEAT_SIGN_MAG];
    assign fact_coef = '{ofs: fact_ofs_ff, gain: fact_gain_ff};
    assign user_coef = '{ofs: user_ofs_ff, gain: user_gain_ff};

    // ---------------- watchdog ----------------
    // arriving data wins over a simultaneous expiry
    logic [WCNT_W-1:0] nxt_wcnt;
    logic nxt_expired;

    assign nxt_wcnt = pd.valid ? WCNT_ZERO
                    : (wcnt_ff == WCNT_LAST) ? wcnt_ff
                    : wcnt_ff + WCNT_W'(1);
    assign nxt_expired = pd.valid ? 1'b0
                       : (wcnt_ff == WCNT_LAST) ? 1'b1
                       : expired_ff;

    // starts expired: nothing is driven from process data until the first word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wcnt_ff <= WCNT_ZERO;
            expired_ff <= 1'b1;
        end else if (ce) begin
            wcnt_ff <= nxt_wcnt;
            expired_ff <= nxt_expired;
        end
    end

    assign run_led = !expired_ff;

    // ---------------- channels ----------------
    logic [15:0] word_ff [NUM_CH];
    logic [11:0] dac_ff [NUM_CH];
    logic [11:0] code_w [NUM_CH];

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic take;
        logic [11:0] nxt_dac;

        assign take = pd.valid && (pd.ch == CH_W'(g));
        assign nxt_dac = expired_ff ? subst_ff[11:0] : code_w[g];

        aows_scaler u_scaler (
            .word(word_ff[g]),
            .sign_mag(sign_mag),
            .fact_en(fact_en),
            .user_en(user_en),
            .fact(fact_coef),
            .user(user_coef),
            .code(code_w[g])
        );

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                word_ff[g] <= RST_WORD;
                dac_ff[g] <= CODE_ZERO;
            end else if (ce) begin
                if (take) begin
                    word_ff[g] <= pd.word;
                end
                dac_ff[g] <= nxt_dac;
            end
        end

        assign dac_code[g] = dac_ff[g];
    end

    // ---------------- checks on channels 0 and 3 and on the watchdog ----------------
    logic plain0;
    logic unity_f;
    logic unity_u;
    logic [11:0] w0_code;

    assign plain0 = ce && !expired_ff && !sign_mag;
    assign unity_f = (fact_gain_ff == GAIN_UNITY) && (fact_ofs_ff == RST_OFS);
    assign unity_u = (user_gain_ff == GAIN_UNITY) && (user_ofs_ff == RST_OFS);
    assign w0_code = word_ff[0][CODE_LSB+11:CODE_LSB];

    property p_full_scale;
        @(posedge clk) disable iff (!reset_n)
        plain0 && !fact_en && !user_en && word_ff[0] == WORD_FULL
        |=> dac_ff[0] == CODE_MAX;
    endproperty
    a_full_scale: assert property (p_full_scale)
        else $error("full scale word did not give the top code");

    property p_mid_scale;
        @(posedge clk) disable iff (!reset_n)
        plain0 && !fact_en && !user_en && word_ff[0] == WORD_HALF
        |=> dac_ff[0] == CODE_MID;
    endproperty
    a_mid_scale: assert property (p_mid_scale)
        else $error("half scale word did not give the mid code");

    property p_minus_one;
        @(posedge clk) disable iff (!reset_n)
        plain0 && !fact_en && !user_en && word_ff[0] == WORD_MINUS_ONE
        |=> dac_ff[0] == CODE_ZERO;
    endproperty
    a_minus_one: assert property (p_minus_one)
        else $error("word minus one was not treated as negative");

    property p_sign_mag;
        @(posedge clk) disable iff (!reset_n)
        ce && !expired_ff && sign_mag && !fact_en && !user_en
        && word_ff[0] == WORD_SM_NEG
        |=> dac_ff[0] == CODE_ZERO;
    endproperty
    a_sign_mag: assert property (p_sign_mag)
        else $error("sign magnitude negative word gave a nonzero code");

    property p_wdog_feed;
        @(posedge clk) disable iff (!reset_n)
        ce && pd.valid |=> !expired_ff && run_led;
    endproperty
    a_wdog_feed: assert property (p_wdog_feed)
        else $error("process data did not relight the run indicator");

    property p_wdog_expire;
        @(posedge clk) disable iff (!reset_n)
        ce && !pd.valid && wcnt_ff == WCNT_LAST |=> expired_ff && !run_led;
    endproperty
    a_wdog_expire: assert property (p_wdog_expire)
        else $error("watchdog did not expire at its limit");

    property p_substitute;
        @(posedge clk) disable iff (!reset_n)
        ce && expired_ff |=> dac_ff[0] == $past(subst_ff[11:0]);
    endproperty
    a_substitute: assert property (p_substitute)
        else $error("expired output is not the substitute value");

    property p_pass;
        @(posedge clk) disable iff (!reset_n)
        plain0 && !fact_en && !user_en && !word_ff[0][15]
        |=> dac_ff[0] == $past(w0_code);
    endproperty
    a_pass: assert property (p_pass)
        else $error("unscaled word did not pass through");

    property p_fact_only;
        @(posedge clk) disable iff (!reset_n)
        plain0 && fact_en && !user_en && unity_f && !word_ff[0][15]
        |=> dac_ff[0] == $past(w0_code);
    endproperty
    a_fact_only: assert property (p_fact_only)
        else $error("unity factory scaling changed the code");

    property p_user_only;
        @(posedge clk) disable iff (!reset_n)
        plain0 && !fact_en && user_en && unity_u && !word_ff[0][15]
        |=> dac_ff[0] == $past(w0_code);
    endproperty
    a_user_only: assert property (p_user_only)
        else $error("unity user scaling changed the code");

    property p_chain;
        @(posedge clk) disable iff (!reset_n)
        plain0 && fact_en && user_en && unity_f && user_gain_ff == GAIN_UNITY
        && user_ofs_ff == WORD_FULL && word_ff[0] == WORD_ZERO
        |=> dac_ff[0] == CODE_MAX;
    endproperty
    a_chain: assert property (p_chain)
        else $error("user offset not applied after factory stage");

    property p_clamp;
        @(posedge clk) disable iff (!reset_n)
        plain0 && fact_en && !user_en && fact_gain_ff == GAIN_UNITY
        && fact_ofs_ff == WORD_FULL && word_ff[0] == WORD_FULL
        |=> dac_ff[0] == CODE_MAX;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("overrange result wrapped instead of clamping");

    property p_subst_last;
        @(posedge clk) disable iff (!reset_n)
        ce && expired_ff |=> dac_ff[NUM_CH-1] == $past(subst_ff[11:0]);
    endproperty
    a_subst_last: assert property (p_subst_last)
        else $error("last channel did not take the substitute value");

    // a frozen enable must not let the timeout run on
    property p_wdog_freeze;
        @(posedge clk) disable iff (!reset_n)
        !ce |=> $stable(wcnt_ff) && $stable(expired_ff);
    endproperty
    a_wdog_freeze: assert property (p_wdog_freeze)
        else $error("watchdog moved while the clock enable was low");
endmodule : aows_top
`default_nettype wire

// *** verification/aows_coupler.sv ***
// bus coupler model: delivers process data words to the scaler
`timescale 1ns/100ps
`default_nettype none
module aows_coupler import aows_pkg::*; (
    input wire logic clk,
    output var aows_pd_t pd
);
    initial begin
        pd = '{valid: 1'b0, ch: 2'h0, word: 16'h5a5a};
    end

    // called right after a rising edge; last=0 keeps valid up for a back-to-back word
    task automatic send(input logic [1:0] ch, input logic [15:0] word, input bit last);
        pd <= '{valid: 1'b1, ch: ch, word: word};
        @(posedge clk);
        if (last) begin
            // idle fields are inverted so a design that ignores valid sees garbage
            pd <= '{valid: 1'b0, ch: ~ch, word: ~word};
        end
    endtask : send
endmodule : aows_coupler
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking testbench for the analog output word scaler
`timescale 1ns/100ps
`default_nettype none
module tb_top import aows_pkg::*; ;
    // short watchdog so an expiry fits into a quick run
    localparam int WDOG = 200;
    logic clk = 1'b0;
    logic reset_n, ce, hsel, hwrite, hreadyout, run_led;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize;
    aows_pd_t pd;
    logic [NUM_CH-1:0][CODE_W-1:0] dac_code;
    logic [15:0] fo, fg, uo, ug;
    logic [7:0] idxs [7] = '{IDX_FACT_OFS, IDX_FACT_GAIN, IDX_FEATURE, IDX_USER_OFS,
                             IDX_USER_GAIN, IDX_SUBST, IDX_STATUS};
    logic [15:0] rsts [7] = '{RST_OFS, RST_GAIN, RST_FEATURE, RST_OFS, RST_GAIN,
                              RST_SUBST, 16'h0001};
    logic [15:0] words [3] = '{16'h1000, 16'h3000, 16'h0008};
    logic [15:0] fwords [2] = '{16'hffff, 16'h8008};
    logic [2:0] fmts [2] = '{3'b001, 3'b101};
    int fails = 0;
    int compares = 0;
    int n;

    always #5 clk = ~clk;

    aows_top #(.WDOG_CYCLES(WDOG)) i_aows_top (.clk(clk), .reset_n(reset_n), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .pd(pd), .dac_code(dac_code), .run_led(run_led));
    aows_coupler i_aows_coupler (.clk(clk), .pd(pd));

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: register read %h, expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_code(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: converter code %h, expected %h", $time, got, exp);
        end
    endtask : cmp_code

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    // one single ahb-lite transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= 32'({idx, 2'b00});
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        cmp_reg({30'h0, hresp}, {30'h0, HRESP_OKAY});
    endtask : bus

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        cmp_reg(rd, exp);
    endtask : rdchk

    task automatic set_coefs(input logic [15:0] a, b, c, d);
        fo = a;
        fg = b;
        uo = c;
        ug = d;
        bus(1'b1, IDX_FACT_OFS, {16'h0000, a});
        bus(1'b1, IDX_FACT_GAIN, {16'h0000, b});
        bus(1'b1, IDX_USER_OFS, {16'h0000, c});
        bus(1'b1, IDX_USER_GAIN, {16'h0000, d});
    endtask : set_coefs

    function automatic longint sat(input longint x);
        return (x > 65535) ? 65535 : ((x < -65536) ? -65536 : x);
    endfunction : sat

    function automatic logic [11:0] exp_code(input logic [15:0] w, input logic [2:0] f);
        longint v;
        v = f[FEAT_SIGN_MAG] ? (w[15] ? -longint'(w[14:0]) : longint'(w[14:0]))
                             : longint'($signed(w));
        if (f[FEAT_FACT_EN]) v = sat(longint'($signed(fo)) + ((longint'(fg) * v) >>> GAIN_FRAC));
        if (f[FEAT_USER_EN]) v = sat(longint'($signed(uo)) + ((longint'(ug) * v) >>> GAIN_FRAC));
        if (v < 0) return CODE_ZERO;
        if (v > 32767) return CODE_MAX;
        return 12'(v >>> CODE_LSB);
    endfunction : exp_code

    task automatic run_case(input logic [2:0] f, input logic [15:0] w, input logic [1:0] ch);
        bus(1'b1, IDX_FEATURE, {29'h0, f});
        i_aows_coupler.send(ch, w, 1'b1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_code(dac_code[ch], exp_code(w, f));
    endtask : run_case

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, fails);
    endtask : end_test

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(20_000 * 10);
        fails++;
        $display("ERROR %0t: run did not complete in time", $time);
        tally_and_finish();
    end

    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0000_0000;
        repeat (12) @(posedge clk);
        @(negedge clk);
        cmp_bit(run_led, 1'b0);
        cmp_code(dac_code[0], CODE_ZERO);
        @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) rdchk(idxs[i], {16'h0000, rsts[i]});
        for (int i = 0; i < 6; i++) bus(1'b1, idxs[i], 32'habcd_1230 + i);
        for (int i = 0; i < 6; i++) rdchk(idxs[i], 32'h0000_1230 + i);
        bus(1'b1, IDX_STATUS, 32'h0000_0000);
        rdchk(IDX_STATUS, 32'h0000_0001);
        bus(1'b1, 8'h30, 32'h0000_ffff);
        rdchk(8'h30, 32'h0000_0000);
        end_test("registers");
        set_coefs(RST_OFS, RST_GAIN, RST_OFS, RST_GAIN);
        bus(1'b1, IDX_FEATURE, {16'h0000, RST_FEATURE});
        bus(1'b1, IDX_SUBST, {16'h0000, RST_SUBST});
        i_aows_coupler.send(2'd0, WORD_ZERO, 1'b0);
        i_aows_coupler.send(2'd1, WORD_HALF, 1'b0);
        i_aows_coupler.send(2'd2, WORD_FULL, 1'b0);
        i_aows_coupler.send(2'd3, WORD_MINUS_ONE, 1'b1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_code(dac_code[0], CODE_ZERO);
        cmp_code(dac_code[1], CODE_MID);
        cmp_code(dac_code[2], CODE_MAX);
        cmp_code(dac_code[3], CODE_ZERO);
        cmp_bit(run_led, 1'b1);
        end_test("default format");
        // gains chosen so every product is exact and rounding cannot matter
        set_coefs(16'h0100, 16'h0200, 16'hff00, 16'h0080);
        for (int m = 0; m < 4; m++) begin
            for (int j = 0; j < 3; j++) begin
                run_case(3'(m), words[j], 2'(j));
            end
        end
        run_case(3'b010, 16'h7ffe, 2'd3);
        end_test("scaling");
        set_coefs(RST_OFS, RST_GAIN, 16'h0010, GAIN_UNITY);
        for (int i = 0; i < 2; i++) begin
            for (int j = 0; j < 2; j++) run_case(fmts[i], fwords[j], 2'(j));
        end
        end_test("formats");
        set_coefs(RST_OFS, GAIN_UNITY, RST_OFS, GAIN_UNITY);
        run_case(3'b000, WORD_FULL, 2'h0);
        run_case(3'b000, WORD_HALF, 2'h0);
        run_case(3'b000, WORD_MINUS_ONE, 2'h0);
        run_case(3'b100, WORD_SM_NEG, 2'h0);
        run_case(3'b010, 16'h1000, 2'h0);
        run_case(3'b001, 16'h1000, 2'h0);
        set_coefs(RST_OFS, GAIN_UNITY, WORD_FULL, GAIN_UNITY);
        run_case(3'b011, WORD_ZERO, 2'h0);
        set_coefs(WORD_FULL, GAIN_UNITY, RST_OFS, GAIN_UNITY);
        run_case(3'b010, WORD_FULL, 2'h0);
        end_test("channel zero corners");
        bus(1'b1, IDX_SUBST, 32'h0000_0abc);
        rdchk(IDX_SUBST, 32'h0000_0abc);
        i_aows_coupler.send(2'd0, 16'h1000, 1'b1);
        ce <= 1'b0;
        repeat (WDOG + 20) @(posedge clk);
        @(negedge clk);
        cmp_bit(run_led, 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        n = 0;
        while (run_led === 1'b1 && n < WDOG + 10) begin
            @(negedge clk);
            n++;
        end
        cmp_bit(1'(n >= WDOG - 5 && n <= WDOG + 2), 1'b1);
        repeat (2) @(posedge clk);
        @(negedge clk);
        for (int c = 0; c < NUM_CH; c++) cmp_code(dac_code[c], 12'habc);
        rdchk(IDX_STATUS, 32'h0000_0001);
        i_aows_coupler.send(2'd2, WORD_FULL, 1'b1);
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp_bit(run_led, 1'b1);
        end_test("watchdog");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
